// ### hdl/fsl_pkg.sv
package fsl_pkg;
  // ----------------------------------------------------------------
  // Security word and location
  // ----------------------------------------------------------------
  localparam int unsigned FSL_ADDR_W = 16;
  localparam int unsigned FSL_DATA_W = 16;
  localparam logic [15:0] FSL_SEC_ADDR = 16'h1FF7;
  localparam logic [15:0] FSL_SEC_WORD = 16'hE70A;
  localparam logic [15:0] FSL_UNSEC_WORD = 16'h0000;
  // ----------------------------------------------------------------
  // TAP
  // ----------------------------------------------------------------
  localparam int unsigned FSL_IR_W = 4;
  localparam logic [3:0] FSL_IR_IDCODE = 4'h2;
  localparam logic [3:0] FSL_IR_RECOVER = 4'h8;
  localparam logic [3:0] FSL_IR_DEBUG = 4'h7;
  localparam logic [3:0] FSL_IR_BYPASS = 4'hF;
  localparam int unsigned FSL_DIV_W = 7;
  localparam int unsigned FSL_TMS_RESET_CNT = 5;
  // Arbitrary neutral identification value
  localparam logic [31:0] FSL_IDCODE_VAL = 32'h1234_5001;
  typedef enum logic [1:0] {FSL_OP_NONE, FSL_OP_PROG, FSL_OP_ERASE} fsl_op_e;
endpackage

// ### hdl/fsl_lockout.sv
`timescale 1ns/1ps
module fsl_lockout (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [fsl_pkg::FSL_DATA_W-1:0] sec_loc_rdata,
  input wire logic fl_prog_req,
  input wire logic [fsl_pkg::FSL_ADDR_W-1:0] fl_prog_addr,
  input wire logic [fsl_pkg::FSL_DATA_W-1:0] fl_prog_wdata,
  input wire logic [fsl_pkg::FSL_DATA_W-1:0] fl_prog_old,
  output logic fl_wr,
  output logic [fsl_pkg::FSL_ADDR_W-1:0] fl_wr_addr,
  output logic [fsl_pkg::FSL_DATA_W-1:0] fl_wr_data,
  output logic fl_mass_erase,
  output logic [fsl_pkg::FSL_DIV_W-1:0] fl_erase_div,
  input wire logic fl_erase_done,
  output logic prot_clear,
  output logic secured,
  output logic debug_en,
  output logic debug_sel,
  input wire logic debug_tdo,
  output logic recover_busy
);
  import fsl_pkg::*;

  typedef enum logic [3:0] {
    TS_RESET, TS_IDLE, TS_SEL_DR, TS_CAP_DR, TS_SH_DR, TS_EX1_DR, TS_PA_DR, TS_EX2_DR,
    TS_UP_DR, TS_SEL_IR, TS_CAP_IR, TS_SH_IR, TS_EX1_IR, TS_PA_IR, TS_EX2_IR, TS_UP_IR
  } fsl_tap_e;

  typedef struct packed {
    logic latched;
    logic secured;
    fsl_tap_e tap;
    logic [FSL_IR_W-1:0] ir_sh;
    logic [FSL_IR_W-1:0] ir;
    logic [31:0] dr_sh;
    logic [FSL_DIV_W-1:0] div;
    logic div_upd;
    logic erasing;
    logic erase_req;
    logic prot_clr;
    logic wr;
    logic [FSL_ADDR_W-1:0] wr_addr;
    logic [FSL_DATA_W-1:0] wr_data;
    logic tdo;
    logic tdo_oe;
    logic tck_d;
    logic [2:0] tms_hi;
  } fsl_state_s;

  fsl_state_s st_reg;
  fsl_state_s st_next;
  logic tck_rise;
  logic tck_fall;

  // ----------------------------------------------------------------
  // TAP next state
  // ----------------------------------------------------------------
  function automatic fsl_tap_e fsl_tap_step(input fsl_tap_e s, input logic m);
    unique case (s)
      TS_RESET: fsl_tap_step = m ? TS_RESET : TS_IDLE;
      TS_IDLE: fsl_tap_step = m ? TS_SEL_DR : TS_IDLE;
      TS_SEL_DR: fsl_tap_step = m ? TS_SEL_IR : TS_CAP_DR;
      TS_CAP_DR: fsl_tap_step = m ? TS_EX1_DR : TS_SH_DR;
      TS_SH_DR: fsl_tap_step = m ? TS_EX1_DR : TS_SH_DR;
      TS_EX1_DR: fsl_tap_step = m ? TS_UP_DR : TS_PA_DR;
      TS_PA_DR: fsl_tap_step = m ? TS_EX2_DR : TS_PA_DR;
      TS_EX2_DR: fsl_tap_step = m ? TS_UP_DR : TS_SH_DR;
      TS_UP_DR: fsl_tap_step = m ? TS_SEL_DR : TS_IDLE;
      TS_SEL_IR: fsl_tap_step = m ? TS_RESET : TS_CAP_IR;
      TS_CAP_IR: fsl_tap_step = m ? TS_EX1_IR : TS_SH_IR;
      TS_SH_IR: fsl_tap_step = m ? TS_EX1_IR : TS_SH_IR;
      TS_EX1_IR: fsl_tap_step = m ? TS_UP_IR : TS_PA_IR;
      TS_PA_IR: fsl_tap_step = m ? TS_EX2_IR : TS_PA_IR;
      TS_EX2_IR: fsl_tap_step = m ? TS_UP_IR : TS_SH_IR;
      TS_UP_IR: fsl_tap_step = m ? TS_SEL_DR : TS_IDLE;
    endcase
  endfunction

  // TCK is sampled as an ordinary input on the system clock
  assign tck_rise = tck & ~st_reg.tck_d;
  assign tck_fall = ~tck & st_reg.tck_d;

  always_comb begin
    st_next = st_reg;
    st_next.tck_d = tck;
    st_next.erase_req = 1'b0;
    st_next.prot_clr = 1'b0;
    st_next.wr = 1'b0;
    // ----------------------------------------------------------------
    // Secured flag, sampled once after reset release
    // ----------------------------------------------------------------
    if (!st_reg.latched) begin
      st_next.latched = 1'b1;
      st_next.secured = (sec_loc_rdata == FSL_SEC_WORD);
    end
    // ----------------------------------------------------------------
    // TAP, clocked by TCK edges
    // ----------------------------------------------------------------
    if (tck_rise) begin
      // Five TMS-high rises always reach reset from any state
      st_next.tap = fsl_tap_step(st_reg.tap, tms);
      // Run of TMS-high rises, saturating at the reset count
      if (!tms) begin
        st_next.tms_hi = 3'h0;
      end else if (st_reg.tms_hi != 3'(FSL_TMS_RESET_CNT)) begin
        st_next.tms_hi = st_reg.tms_hi + 3'h1;
      end
      unique case (st_reg.tap)
        TS_CAP_IR: st_next.ir_sh = 4'h1;
        TS_SH_IR: st_next.ir_sh = {tdi, st_reg.ir_sh[FSL_IR_W-1:1]};
        TS_CAP_DR: begin
          st_next.dr_sh = (st_reg.ir == FSL_IR_IDCODE) ? FSL_IDCODE_VAL : 32'h0000_0000;
        end
        TS_SH_DR: begin
          if (st_reg.ir == FSL_IR_RECOVER) begin
            st_next.dr_sh = {25'h0000000, tdi, st_reg.dr_sh[FSL_DIV_W-1:1]};
          end else if (st_reg.ir == FSL_IR_IDCODE) begin
            st_next.dr_sh = {tdi, st_reg.dr_sh[31:1]};
          end else begin
            st_next.dr_sh = {31'h00000000, tdi};
          end
        end
        default: begin
        end
      endcase
      if (st_reg.tap == TS_UP_IR) begin
        st_next.ir = st_reg.ir_sh;
        st_next.div_upd = 1'b0;
      end
      if (st_reg.tap == TS_UP_DR && st_reg.ir == FSL_IR_RECOVER) begin
        st_next.div = st_reg.dr_sh[FSL_DIV_W-1:0];
        st_next.div_upd = 1'b1;
      end
      // Erase starts only on entry to idle from Update-DR
      if (st_reg.tap == TS_UP_DR && !tms && st_reg.ir == FSL_IR_RECOVER
          && st_next.div_upd && !st_reg.erasing) begin
        st_next.erasing = 1'b1;
        st_next.erase_req = 1'b1;
        st_next.div = st_reg.dr_sh[FSL_DIV_W-1:0];
      end
      if (st_next.tap == TS_RESET) begin
        st_next.ir = FSL_IR_IDCODE;
        st_next.div_upd = 1'b0;
      end
    end
    if (tck_fall) begin
      st_next.tdo_oe = (st_reg.tap == TS_SH_DR) || (st_reg.tap == TS_SH_IR);
      if (st_reg.tap == TS_SH_IR) begin
        st_next.tdo = st_reg.ir_sh[0];
      end else if (st_reg.ir == FSL_IR_DEBUG) begin
        st_next.tdo = debug_tdo & ~st_reg.secured;
      end else begin
        st_next.tdo = st_reg.dr_sh[0];
      end
    end
    // ----------------------------------------------------------------
    // Erase completion; secured flag stays until next reset
    // ----------------------------------------------------------------
    if (st_reg.erasing && fl_erase_done) begin
      st_next.erasing = 1'b0;
      st_next.prot_clr = 1'b1;
    end
    // ----------------------------------------------------------------
    // Program path: bits may only fall
    // ----------------------------------------------------------------
    if (fl_prog_req && !st_reg.erasing) begin
      st_next.wr = 1'b1;
      st_next.wr_addr = fl_prog_addr;
      st_next.wr_data = fl_prog_old & fl_prog_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '{latched: 1'b0, secured: 1'b1, tap: TS_RESET, ir_sh: 4'h0,
                  ir: FSL_IR_IDCODE, dr_sh: 32'h0000_0000, div: 7'h00, div_upd: 1'b0,
                  erasing: 1'b0, erase_req: 1'b0, prot_clr: 1'b0, wr: 1'b0,
                  wr_addr: 16'h0000, wr_data: 16'h0000, tdo: 1'b0, tdo_oe: 1'b0,
                  tck_d: 1'b0, tms_hi: 3'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign tdo = st_reg.tdo;
  assign tdo_oe = st_reg.tdo_oe;
  assign fl_wr = st_reg.wr;
  assign fl_wr_addr = st_reg.wr_addr;
  assign fl_wr_data = st_reg.wr_data;
  assign fl_mass_erase = st_reg.erase_req;
  assign fl_erase_div = st_reg.div;
  assign prot_clear = st_reg.prot_clr;
  assign secured = st_reg.secured;
  assign recover_busy = st_reg.erasing;
  // Debug port held off until the flag is known
  assign debug_en = st_reg.latched & ~st_reg.secured;
  assign debug_sel = debug_en && (st_reg.ir == FSL_IR_DEBUG);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_debug_gate: assert property (@(posedge ref_clk) disable iff (!resetn)
    secured |-> !debug_en && !debug_sel) else $error("debug open while secured");
  chk_secure_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_reg.latched && $past(st_reg.latched) |-> $stable(secured))
    else $error("secured flag moved");
  chk_erase_entry: assert property (@(posedge ref_clk) disable iff (!resetn)
    fl_mass_erase |-> st_reg.tap == TS_IDLE && $past(st_reg.tap) == TS_UP_DR)
    else $error("erase not on idle entry");
  chk_prog_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    fl_prog_req && !st_reg.erasing |=> fl_wr && (fl_wr_data & ~$past(fl_prog_old)) == 16'h0000)
    else $error("program raised a bit");
  chk_prot_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
    prot_clear |-> $past(recover_busy) && !recover_busy) else $error("bad clear");
  chk_tms_reset: assert property (@(posedge ref_clk) disable iff (!resetn)
    st_reg.tms_hi == 3'(FSL_TMS_RESET_CNT) |-> st_reg.tap == TS_RESET)
    else $error("tap not reset after tms high run");
  chk_sec_latch: assert property (@(posedge ref_clk) disable iff (!resetn)
    !st_reg.latched |=> secured == ($past(sec_loc_rdata) == FSL_SEC_WORD))
    else $error("flag not from word");
endmodule

// ### dv/fsl_jtag_host.sv
`timescale 1ns/1ps
module fsl_jtag_host (
  input wire logic ref_clk,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // TCK at a fifth of ref_clk, parked low between frames
  task automatic tick(input logic m, input logic d);
    @(negedge ref_clk);
    tck = 1'h0;
    tms = m;
    tdi = d;
    repeat (2) @(negedge ref_clk);
    tck = 1'h1;
    repeat (2) @(negedge ref_clk);
    tck = 1'h0;
    tdi = ~d;
  endtask
  task automatic tap_reset();
    repeat (5) tick(1'h1, 1'h0);
    tick(1'h0, 1'h0);
  endtask
  // From Idle through one scan and back to Idle, LSB first
  task automatic scan(input logic ir, input logic [6:0] v, input int n);
    tick(1'h1, 1'h0);
    if (ir) tick(1'h1, 1'h0);
    tick(1'h0, 1'h0);
    tick(1'h0, 1'h0);
    for (int i = 0; i < n; i++) tick(i == n - 1, v[i]);
    tick(1'h1, 1'h0);
    tick(1'h0, 1'h0);
  endtask
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %s expected %h seen %h", nm, e, a); end end
module tb_top;
  import fsl_pkg::*;
  logic ref_clk = 1'h0;
  logic resetn = 1'h0;
  logic tck, tms, tdi, fl_prog_req, fl_erase_done, debug_tdo;
  logic [15:0] sec_loc_rdata, fl_prog_addr, fl_prog_wdata, fl_prog_old;
  logic fl_wr, fl_mass_erase, prot_clear, secured, debug_en, debug_sel, recover_busy;
  logic tdo, tdo_oe;
  logic [15:0] fl_wr_addr, fl_wr_data, wr_data_cap, wr_addr_cap;
  logic [6:0] fl_erase_div, div_cap;
  int miscompares = 0;
  int samples_checked = 0;
  int cnt [4] = '{0, 0, 0, 0};
  always #25 ref_clk = ~ref_clk;
  fsl_jtag_host host_u (.ref_clk, .tck, .tms, .tdi);
  fsl_lockout dut_u (.ref_clk, .resetn, .tck, .tms, .tdi, .tdo, .tdo_oe, .sec_loc_rdata,
    .fl_prog_req, .fl_prog_addr, .fl_prog_wdata, .fl_prog_old, .fl_wr, .fl_wr_addr,
    .fl_wr_data, .fl_mass_erase, .fl_erase_div, .fl_erase_done, .prot_clear, .secured,
    .debug_en, .debug_sel, .debug_tdo, .recover_busy);
  // Pulses are counted so a wait started late still sees them
  always @(posedge ref_clk) begin
    if (fl_wr === 1'h1) begin
      cnt[0]++;
      wr_data_cap = fl_wr_data;
      wr_addr_cap = fl_wr_addr;
    end
    if (fl_mass_erase === 1'h1) begin
      cnt[1]++;
      div_cap = fl_erase_div;
    end
    if (prot_clear === 1'h1) cnt[2]++;
    if (tdo_oe === 1'h1 && tdo === 1'h1) cnt[3]++;
  end
  task automatic test_done();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_cnt(input int k, input int want);
    for (int t = 0; t < 400 && cnt[k] < want; t++) @(negedge ref_clk);
    `CHK("pulse count", want, cnt[k])
    if (cnt[k] != want) test_done();
  endtask
  task automatic do_reset(input logic [15:0] sec);
    @(negedge ref_clk);
    resetn = 1'h0;
    sec_loc_rdata = sec;
    repeat (8) @(negedge ref_clk);
    resetn = 1'h1;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic prog(input logic [15:0] old, input logic [15:0] wd);
    @(negedge ref_clk);
    fl_prog_req = 1'h1;
    fl_prog_addr = FSL_SEC_ADDR;
    fl_prog_old = old;
    fl_prog_wdata = wd;
    @(negedge ref_clk);
    fl_prog_req = 1'h0;
    fl_prog_wdata = ~wd;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_secured();
    int c0;
    do_reset(FSL_SEC_WORD);
    `CHK("secured", 1'h1, secured)
    `CHK("debug_en", 1'h0, debug_en)
    sec_loc_rdata = FSL_UNSEC_WORD;
    host_u.tap_reset();
    host_u.scan(1'h1, 7'(FSL_IR_DEBUG), 4);
    `CHK("debug_sel", 1'h0, debug_sel)
    `CHK("latched", 1'h1, secured)
    debug_tdo = 1'h1;
    c0 = cnt[3];
    host_u.scan(1'h0, 7'h00, 4);
    `CHK("tdo blocked", c0, cnt[3])
  endtask
  task automatic sc_recover();
    host_u.scan(1'h1, 7'(FSL_IR_RECOVER), 4);
    `CHK("early erase", 0, cnt[1])
    host_u.scan(1'h0, 7'h55, 7);
    wait_cnt(1, 1);
    `CHK("divider", 7'h55, div_cap)
    `CHK("busy", 1'h1, recover_busy)
    prog(16'hFFFF, 16'h0000);
    repeat (3) @(negedge ref_clk);
    `CHK("prog in erase", 0, cnt[0])
    `CHK("still secured", 1'h1, secured)
    fl_erase_done = 1'h1;
    @(negedge ref_clk);
    fl_erase_done = 1'h0;
    wait_cnt(2, 1);
    `CHK("one erase", 1, cnt[1])
    do_reset(16'hFFFF);
    `CHK("unsecured", 1'h0, secured)
    `CHK("debug on", 1'h1, debug_en)
  endtask
  task automatic sc_program();
    do_reset(FSL_SEC_WORD);
    prog(FSL_SEC_WORD, 16'h0F0F);
    wait_cnt(0, 1);
    `CHK("wr data", 16'h070A, wr_data_cap)
    `CHK("wr addr", FSL_SEC_ADDR, wr_addr_cap)
    `CHK("before reset", 1'h1, secured)
    do_reset(FSL_UNSEC_WORD);
    `CHK("after reset", 1'h0, secured)
  endtask
  task automatic sc_tap_reset();
    int c0;
    host_u.tap_reset();
    host_u.scan(1'h1, 7'(FSL_IR_DEBUG), 4);
    `CHK("debug_sel", 1'h1, debug_sel)
    c0 = cnt[3];
    host_u.scan(1'h0, 7'h00, 4);
    `CHK("tdo open", 1'h1, cnt[3] != c0)
    host_u.tap_reset();
    `CHK("tap reset", 1'h0, debug_sel)
  endtask
  initial begin
    sec_loc_rdata = FSL_SEC_WORD;
    {fl_prog_req, fl_erase_done, debug_tdo} = 3'h0;
    {fl_prog_addr, fl_prog_wdata, fl_prog_old} = '0;
    sc_secured();
    sc_recover();
    sc_program();
    sc_tap_reset();
    test_done();
  end
endmodule
